// ### core/fsiu_core.sv
// Four source interrupt unit: flags, masks, master request, entry,
// return stack, test pin branch condition and APB register slave.
// Assumes one 50 MHz clock, the core pulsing instr_done once per retired
// instruction, and asynchronous pins synchronised here.
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "fsiu_regs.svh"

// Function
// - Four maskable sources: external line, three serial port events.
// - Active source sets its own flag bit.
// - All unmasked flags merge into one shared master request.
// - Sources synchronised to clock; equal priority, software polls order.
// - Enable interrupts instruction clears global disable bit.
// - Master request occurrence sets master pending flag.
// - Accept: clear pending, set disable, push PC, jump to 2.
// - Writing one clears a flag; writing zero leaves it.
// - External flag stays set while its condition persists.
// - Coprocessor mode: test pin and external line unused from outside.
// - Branch condition samples active low test input pin.
// - Interrupt entry saves only the program counter.
// - No interrupt accepted right after a multiply instruction.
// - All stack levels storable and reloadable; no product restore.
// - Return stack holds four PC levels, pushable and poppable.
// - Pending request held while interrupts disabled.
// - One instruction after enable runs before interrupt accepted.
module fsiu_core (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire fsiu_pkg::fsiu_apb_req_type apb_req,
  output fsiu_pkg::fsiu_apb_rsp_type     apb_rsp,
  input  wire fsiu_pkg::fsiu_core_req_type core_req,
  output fsiu_pkg::fsiu_core_rsp_type    core_rsp,
  input  wire logic                      external_interrupt,
  input  wire logic                      receive_frame_sync_interrupt,
  input  wire logic                      transmit_frame_sync_interrupt,
  input  wire logic                      serial_frame_interrupt,
  input  wire logic                      branch_test_input_n,
  input  wire logic                      cop_external_event,
  input  wire logic                      cop_test_n
);

  fsiu_pkg::fsiu_state_type s;
  fsiu_pkg::fsiu_state_type next_s;

  logic [4:0]                raw_in;
  logic [`FSIU_NUM_SRC-1:0]  set_flag;
  logic [`FSIU_NUM_SRC-1:0]  clr_flag;
  logic                      master_request;
  logic                      accept;
  logic                      setup;
  logic                      wr_access;
  logic [`FSIU_ADDR_W-1:0]   addr;
  logic [31:0]               ctl_word;
  logic [31:0]               status_word;
  logic [4:0]                filt_next;
  logic                      shift_down;
  logic [`FSIU_PC_W-1:0]     push_value;
  logic [`FSIU_STACK_DEPTH-1:0] level_wr;
  logic [`FSIU_STACK_DEPTH-1:0][`FSIU_PC_W-1:0] stack_next;

  // Pin selection; coprocessor mode feeds the port's own events
  always_comb begin
    raw_in[`FSIU_SRC_EXT] = s.cop_mode ? cop_external_event
                                       : external_interrupt;
    raw_in[`FSIU_SRC_RFS] = receive_frame_sync_interrupt;
    raw_in[`FSIU_SRC_TFS] = transmit_frame_sync_interrupt;
    raw_in[`FSIU_SRC_FRM] = serial_frame_interrupt;
    raw_in[4]             = s.cop_mode ? cop_test_n
                                       : branch_test_input_n;
  end

  // Flag set terms: external is level held, serial events are edges
  for (genvar gs = 0; gs < `FSIU_NUM_SRC; gs++) begin : g_src
    if (gs == `FSIU_SRC_EXT) begin : g_ext
      assign set_flag[gs] = s.filt[gs];
    end else begin : g_serial
      assign set_flag[gs] = (s.sync2[gs] == s.sync3[gs]) && s.sync3[gs]
                            && !s.filt[gs];
    end
  end

  // Per pin filter: a change counts when stages two and three agree
  for (genvar gp = 0; gp < 5; gp++) begin : g_pin
    assign filt_next[gp] = (s.sync2[gp] == s.sync3[gp]) ? s.sync3[gp]
                         : s.filt[gp];
  end

  assign master_request = |(s.interrupt_flag_bits
                            & s.interrupt_mask_bits);

  // Entry at an instruction boundary; disable bit and multiply gate it
  assign accept = core_req.instr_done && s.master_interrupt_pending
                  && !s.global_interrupt_disable
                  && !core_req.multiply_instr;

  assign addr      = apb_req.paddr;
  assign setup     = apb_req.psel && !apb_req.penable;
  assign wr_access = apb_req.psel && apb_req.penable && apb_req.pwrite;

  // Entry push takes the top level ahead of a core push; pop comes last
  assign shift_down = accept || core_req.stack_push;
  assign push_value = accept ? core_req.pc_current
                             : core_req.stack_push_data;

  // Per level: a register write wins over any shift
  for (genvar gl = 0; gl < `FSIU_STACK_DEPTH; gl++) begin : g_level
    logic [`FSIU_PC_W-1:0] shifted;
    logic [`FSIU_PC_W-1:0] popped;

    assign level_wr[gl] = wr_access
                          && addr == 8'(`FSIU_OFF_STACK0 + 4 * gl);
    if (gl == 0) begin : g_top
      assign shifted = push_value;
    end else begin : g_below
      assign shifted = s.stack[gl-1];
    end
    if (gl == `FSIU_STACK_DEPTH-1) begin : g_bottom
      assign popped = s.stack[gl];
    end else begin : g_above
      assign popped = s.stack[gl+1];
    end
    assign stack_next[gl] = level_wr[gl] ? apb_req.pwdata[`FSIU_PC_W-1:0]
                            : shift_down ? shifted
                            : core_req.stack_pop ? popped
                            : s.stack[gl];
  end

  always_comb begin
    clr_flag = '0;
    if (wr_access && addr == `FSIU_OFF_CONTROL) begin
      clr_flag = apb_req.pwdata[`FSIU_CTL_FLAG_LSB +: `FSIU_NUM_SRC];
    end
  end

  always_comb begin
    ctl_word = '0;
    ctl_word[`FSIU_CTL_FLAG_LSB +: `FSIU_NUM_SRC] = s.interrupt_flag_bits;
    ctl_word[`FSIU_CTL_MASK_LSB +: `FSIU_NUM_SRC] = s.interrupt_mask_bits;
    ctl_word[`FSIU_CTL_COP_BIT] = s.cop_mode;
    status_word = '0;
    status_word[`FSIU_ST_DISABLE]  = s.global_interrupt_disable;
    status_word[`FSIU_ST_PENDING]  = s.master_interrupt_pending;
    status_word[`FSIU_ST_TEST_LOW] = !s.filt[4];
    status_word[`FSIU_ST_REQUEST]  = master_request;
    status_word[`FSIU_ST_SRC_LSB +: `FSIU_NUM_SRC] =
      s.filt[`FSIU_NUM_SRC-1:0];
  end

  always_comb begin
    next_s = s;

    // Three stage synchroniser; a change counts when stages two and
    // three agree
    next_s.sync1 = raw_in;
    next_s.sync2 = s.sync1;
    next_s.sync3 = s.sync2;
    next_s.filt  = filt_next;

    // Set wins over a simultaneous clear
    next_s.interrupt_flag_bits = (s.interrupt_flag_bits & ~clr_flag)
                                 | set_flag;

    // Pending flag on each new master request; acceptance clears it
    next_s.request_d = master_request;
    if (accept) begin
      next_s.master_interrupt_pending = 1'b0;
    end
    if (master_request && !s.request_d) begin
      next_s.master_interrupt_pending = 1'b1;
    end

    // Global disable bit
    if (core_req.instr_done && core_req.disable_interrupts_instr) begin
      next_s.global_interrupt_disable = 1'b1;
    end
    if (core_req.instr_done && core_req.enable_interrupts_instr) begin
      next_s.global_interrupt_disable = 1'b0;
    end
    if (accept) begin
      next_s.global_interrupt_disable = 1'b1;
    end

    // Return stack levels from the per level logic
    next_s.stack = stack_next;

    // Register writes
    if (wr_access) begin
      case (addr)
        `FSIU_OFF_CONTROL: begin
          next_s.interrupt_mask_bits =
            apb_req.pwdata[`FSIU_CTL_MASK_LSB +: `FSIU_NUM_SRC];
          next_s.cop_mode = apb_req.pwdata[`FSIU_CTL_COP_BIT];
        end
        default: begin
        end
      endcase
    end

    // Read data and error latched in the setup phase
    if (setup) begin
      next_s.pslverr = 1'b0;
      case (addr)
        `FSIU_OFF_CONTROL: next_s.prdata = ctl_word;
        `FSIU_OFF_STATUS:  next_s.prdata = status_word;
        `FSIU_OFF_STACK0:  next_s.prdata = {20'h00000, s.stack[0]};
        `FSIU_OFF_STACK1:  next_s.prdata = {20'h00000, s.stack[1]};
        `FSIU_OFF_STACK2:  next_s.prdata = {20'h00000, s.stack[2]};
        `FSIU_OFF_STACK3:  next_s.prdata = {20'h00000, s.stack[3]};
        default: begin
          next_s.prdata  = 32'h00000000;
          next_s.pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s                          <= '0;
      s.sync1                    <= `FSIU_RST_SYNC;
      s.sync2                    <= `FSIU_RST_SYNC;
      s.sync3                    <= `FSIU_RST_SYNC;
      s.filt                     <= `FSIU_RST_SYNC;
      s.interrupt_flag_bits      <= `FSIU_RST_FLAGS;
      s.interrupt_mask_bits      <= `FSIU_RST_MASK;
      s.global_interrupt_disable <= `FSIU_RST_DISABLE;
    end else begin
      s <= next_s;
    end
  end

  // Zero wait slave; status read reflects state at the setup edge
  always_comb begin
    apb_rsp.prdata  = s.prdata;
    apb_rsp.pready  = 1'b1;
    apb_rsp.pslverr = s.pslverr && apb_req.psel && apb_req.penable;
  end

  always_comb begin
    core_rsp.int_take                 = accept;
    core_rsp.vector_pc                = `FSIU_VECTOR;
    core_rsp.stack_top                = s.stack[0];
    core_rsp.branch_on_test_low       = !s.filt[4];
    core_rsp.global_interrupt_disable = s.global_interrupt_disable;
    core_rsp.master_interrupt_pending = s.master_interrupt_pending;
  end

endmodule : fsiu_core

// ### core/fsiu_pkg.sv
// Types for the four source interrupt unit.
// Assumes fsiu_regs.svh on the include path.
`include "fsiu_regs.svh"

package fsiu_pkg;

  typedef struct packed {
    logic [`FSIU_ADDR_W-1:0] paddr;
    logic                    psel;
    logic                    penable;
    logic                    pwrite;
    logic [31:0]             pwdata;
  } fsiu_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } fsiu_apb_rsp_type;

  typedef struct packed {
    logic                  instr_done;
    logic                  enable_interrupts_instr;
    logic                  disable_interrupts_instr;
    logic                  multiply_instr;
    logic                  stack_push;
    logic                  stack_pop;
    logic [`FSIU_PC_W-1:0] pc_current;
    logic [`FSIU_PC_W-1:0] stack_push_data;
  } fsiu_core_req_type;

  typedef struct packed {
    logic                  int_take;
    logic [`FSIU_PC_W-1:0] vector_pc;
    logic [`FSIU_PC_W-1:0] stack_top;
    logic                  branch_on_test_low;
    logic                  global_interrupt_disable;
    logic                  master_interrupt_pending;
  } fsiu_core_rsp_type;

  typedef struct packed {
    logic [4:0]  sync1;
    logic [4:0]  sync2;
    logic [4:0]  sync3;
    logic [4:0]  filt;
    logic [`FSIU_NUM_SRC-1:0] interrupt_flag_bits;
    logic [`FSIU_NUM_SRC-1:0] interrupt_mask_bits;
    logic        cop_mode;
    logic        global_interrupt_disable;
    logic        master_interrupt_pending;
    logic        request_d;
    logic [`FSIU_STACK_DEPTH-1:0][`FSIU_PC_W-1:0] stack;
    logic [31:0] prdata;
    logic        pslverr;
  } fsiu_state_type;

endpackage : fsiu_pkg

// ### core/fsiu_regs.svh
// Constants for the four source interrupt unit: offsets, fields, resets.
// Included by the package and the core; holds definitions only.
`ifndef FSIU_REGS_SVH
`define FSIU_REGS_SVH

`define FSIU_ADDR_W        8
`define FSIU_PC_W          12
`define FSIU_STACK_DEPTH   4
`define FSIU_NUM_SRC       4

// Register byte offsets
`define FSIU_OFF_CONTROL   8'h00
`define FSIU_OFF_STATUS    8'h04
`define FSIU_OFF_STACK0    8'h08
`define FSIU_OFF_STACK1    8'h0c
`define FSIU_OFF_STACK2    8'h10
`define FSIU_OFF_STACK3    8'h14

// Control fields
`define FSIU_CTL_FLAG_LSB  0
`define FSIU_CTL_MASK_LSB  4
`define FSIU_CTL_COP_BIT   8

// Status fields
`define FSIU_ST_DISABLE    0
`define FSIU_ST_PENDING    1
`define FSIU_ST_TEST_LOW   2
`define FSIU_ST_REQUEST    3
`define FSIU_ST_SRC_LSB    4

// Source bit positions
`define FSIU_SRC_EXT       0
`define FSIU_SRC_RFS       1
`define FSIU_SRC_TFS       2
`define FSIU_SRC_FRM       3

// Reset values
`define FSIU_RST_MASK      4'h0
`define FSIU_RST_FLAGS     4'h0
`define FSIU_RST_DISABLE   1'b1
`define FSIU_RST_SYNC      5'h10

// Interrupt entry address
`define FSIU_VECTOR        12'h002

`endif

// ### tb/fsiu_core_test.sv
// Self-checking bench for the interrupt unit.
// Drives APB, core strobes and the far side model; reads are queued.
`timescale 1ns/1ps
module fsiu_core_test;
  logic                        ref_clk = 1'b0;
  logic                        rst_n = 1'b0;
  fsiu_pkg::fsiu_apb_req_type  apb_req = '0;
  fsiu_pkg::fsiu_apb_rsp_type  apb_rsp;
  fsiu_pkg::fsiu_core_req_type core_req = '0;
  fsiu_pkg::fsiu_core_rsp_type core_rsp;
  logic [3:0]                  pulse = '0;
  logic [3:0]                  src;
  logic                        ext_hold = 1'b0;
  logic                        test_low = 1'b0;
  logic                        cop = 1'b0;
  logic                        test_n;
  logic                        cop_event;
  logic                        cop_test_n;
  logic [32:0]                 expq[$];
  logic [11:0]                 pc;
  logic [11:0]                 stk[4];
  int                          failures = 0;
  int                          n_checks = 0;
  int                          cycles = 0;

  always #10 ref_clk = ~ref_clk;

  fsiu_core i_fsiu_core (.ref_clk, .rst_n, .apb_req, .apb_rsp, .core_req,
    .core_rsp, .external_interrupt(src[0]),
    .receive_frame_sync_interrupt(src[1]),
    .transmit_frame_sync_interrupt(src[2]), .serial_frame_interrupt(src[3]),
    .branch_test_input_n(test_n), .cop_external_event(cop_event),
    .cop_test_n);
  fsiu_source_model i_fsiu_source_model (.ref_clk, .pulse, .ext_hold,
    .test_low, .cop, .src, .test_n, .cop_event, .cop_test_n);

  task automatic final_report;
    if (failures == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge ref_clk);
    apb_req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    @(posedge ref_clk);
    while (apb_rsp.pready !== 1'b1) @(posedge ref_clk);
    apb_req <= '0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [32:0] exp);
    expq.push_back(exp);
    apb(a, 1'b0, 32'h0);
  endtask : rd

  // Bits: retire, enable, multiply, push, pop
  task automatic core(input logic [4:0] k, input logic [11:0] p);
    fsiu_pkg::fsiu_core_req_type r;
    r = '0;
    {r.instr_done, r.enable_interrupts_instr, r.multiply_instr,
     r.stack_push, r.stack_pop} = k;
    r.pc_current = p;
    r.stack_push_data = p;
    @(posedge ref_clk);
    core_req <= r;
    @(posedge ref_clk);
    core_req <= '0;
  endtask : core

  task automatic fire(input logic [3:0] p);
    @(posedge ref_clk);
    pulse <= p;
    @(posedge ref_clk);
    pulse <= '0;
    repeat (12) @(posedge ref_clk);
  endtask : fire

  always @(negedge ref_clk)
    if (apb_req.psel && apb_req.penable && apb_rsp.pready &&
      !apb_req.pwrite && expq.size() > 0)
      check({apb_rsp.pslverr, apb_rsp.prdata}, expq.pop_front());

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      final_report();
    end
  end

  initial begin
    void'($urandom(32'h4676));
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(8'h00, 33'h0);
    rd(8'h04, 33'h1);
    rd(8'h18, 33'h100000000);
    apb(8'h00, 1'b1, 32'hf0);
    rd(8'h00, 33'hf0);
    for (int i = 0; i < 4; i++) begin
      fire(4'(1 << i));
      apb(8'h00, 1'b1, 32'hf0);
      rd(8'h00, 33'hf0 | 33'(1 << i));
      rd(8'h04, 33'h0b);
      apb(8'h00, 1'b1, 32'hf0 | 32'(1 << i));
      rd(8'h00, 33'hf0);
    end
    ext_hold <= 1'b1;
    repeat (8) @(posedge ref_clk);
    apb(8'h00, 1'b1, 32'hf1);
    rd(8'h00, 33'hf1);
    ext_hold <= 1'b0;
    repeat (8) @(posedge ref_clk);
    apb(8'h00, 1'b1, 32'hf1);
    rd(8'h00, 33'hf0);
    pc = 12'($urandom);
    core(5'b11000, 12'h0);
    core(5'b10100, 12'h0);
    rd(8'h04, 33'h2);
    core(5'b10000, pc);
    rd(8'h04, 33'h1);
    rd(8'h08, {21'h0, pc});
    apb(8'h00, 1'b1, 32'h0);
    fire(4'h2);
    rd(8'h00, 33'h2);
    rd(8'h04, 33'h1);
    apb(8'h00, 1'b1, 32'h2);
    for (int i = 0; i < 4; i++) begin
      stk[i] = 12'($urandom);
      core(5'b00010, stk[i]);
    end
    for (int i = 0; i < 4; i++)
      rd(8'(8 + 4 * i), {21'h0, stk[3 - i]});
    core(5'b00001, 12'h0);
    rd(8'h08, {21'h0, stk[2]});
    apb(8'h14, 1'b1, 32'h5a5);
    rd(8'h14, 33'h5a5);
    test_low <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(8'h04, 33'h5);
    apb(8'h00, 1'b1, 32'h1f0);
    cop <= 1'b1;
    fire(4'h1);
    rd(8'h00, 33'h1f1);
    rd(8'h04, 33'hf);
    apb(8'h00, 1'b1, 32'h1f1);
    rd(8'h00, 33'h1f0);
    repeat (2) @(posedge ref_clk);
    final_report();
  end
endmodule : fsiu_core_test

// ### tb/fsiu_monitor.sv
// Port checker for the interrupt unit.
// Bound into fsiu_core; sees only its ports.
`timescale 1ns/1ps
module fsiu_monitor (
  input wire logic                        ref_clk,
  input wire logic                        rst_n,
  input wire fsiu_pkg::fsiu_apb_req_type  apb_req,
  input wire fsiu_pkg::fsiu_apb_rsp_type  apb_rsp,
  input wire fsiu_pkg::fsiu_core_req_type core_req,
  input wire fsiu_pkg::fsiu_core_rsp_type core_rsp,
  input wire logic                        branch_test_input_n,
  input wire logic                        cop_test_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic cop_q;
  logic take_ok;
  assign take_ok = core_req.instr_done && !core_req.multiply_instr &&
    core_rsp.master_interrupt_pending && !core_rsp.global_interrupt_disable;
  // Coprocessor mode copy, from control writes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) cop_q <= 1'b0;
    else if (apb_req.psel && apb_req.penable && apb_req.pwrite &&
      apb_req.paddr == 8'h00) cop_q <= apb_req.pwdata[8];
  end
  AST_TAKE_COND: assert property (
    core_rsp.int_take |-> take_ok) else $error("accept without cause");
  AST_TAKE_DUE: assert property (
    take_ok |-> core_rsp.int_take) else $error("accept missing");
  AST_ENTRY: assert property (
    core_rsp.int_take |=> core_rsp.global_interrupt_disable &&
    core_rsp.stack_top == $past(core_req.pc_current))
    else $error("entry state wrong");
  AST_VECTOR: assert property (
    core_rsp.vector_pc == 12'h002) else $error("vector wrong");
  AST_ENABLE: assert property (
    core_req.instr_done && core_req.enable_interrupts_instr &&
    !core_rsp.int_take |=> !core_rsp.global_interrupt_disable)
    else $error("enable not taken");
  AST_HOLD: assert property (
    core_rsp.master_interrupt_pending && !core_rsp.int_take |=>
    core_rsp.master_interrupt_pending) else $error("pending lost");
  AST_PUSH: assert property (
    core_req.stack_push && !core_rsp.int_take |=>
    core_rsp.stack_top == $past(core_req.stack_push_data))
    else $error("push wrong");
  AST_TEST: assert property (
    (!cop_q && $stable(branch_test_input_n))[*6] |->
    core_rsp.branch_on_test_low == !branch_test_input_n)
    else $error("test pin not followed");
  AST_COP_TEST: assert property (
    (cop_q && !cop_test_n)[*6] |-> core_rsp.branch_on_test_low)
    else $error("coprocessor test not followed");
  cover property (core_rsp.int_take);
  cover property (apb_rsp.pslverr);
  cover property (core_req.stack_push);
  cover property (cop_q && core_rsp.branch_on_test_low);
endmodule : fsiu_monitor

bind fsiu_core fsiu_monitor i_fsiu_monitor (.ref_clk, .rst_n, .apb_req,
  .apb_rsp, .core_req, .core_rsp, .branch_test_input_n, .cop_test_n);

// ### tb/fsiu_source_model.sv
// Far side: external line, serial events, test and coprocessor pins.
// Bench requests events; each stays high four cycles.
`timescale 1ns/1ps
module fsiu_source_model (
  input  wire logic       ref_clk,
  input  wire logic [3:0] pulse,
  input  wire logic       ext_hold,
  input  wire logic       test_low,
  input  wire logic       cop,
  output logic [3:0]      src,
  output logic            test_n,
  output logic            cop_event,
  output logic            cop_test_n
);
  logic [3:0][3:0] shape = '0;
  logic [3:0]      lvl;
  always @(posedge ref_clk) shape <= {shape[2:0], pulse};
  assign lvl = shape[0] | shape[1] | shape[2] | shape[3];
  // External line and test pin idle in coprocessor mode
  assign src = {lvl[3:1], (lvl[0] | ext_hold) & !cop};
  assign cop_event = cop & (lvl[0] | ext_hold);
  assign test_n = !(test_low & !cop);
  assign cop_test_n = !(test_low & cop);
endmodule : fsiu_source_model
